//--- hdl/aie_pkg.sv
// Purpose: Shared constants and types of the accelerometer interrupt and event logic.
// Assumes: One 200 MHz clock, synchronous active-low reset, byte-wide register port.
// Notes:   Field positions and encodings are shared by the design and its bench.
package aie_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_ACT_THR = 8'h24;
	localparam logic [7:0] ADDR_INACT_THR = 8'h25;
	localparam logic [7:0] ADDR_INACT_DUR = 8'h26;
	localparam logic [7:0] ADDR_ENABLE = 8'h2e;
	localparam logic [7:0] ADDR_ROUTE = 8'h2f;
	localparam logic [7:0] ADDR_SOURCE = 8'h30;
	localparam logic [7:0] ADDR_FORMAT = 8'h31;
	localparam logic [7:0] ADDR_DATA_FIRST = 8'h32;
	localparam logic [7:0] ADDR_DATA_LAST = 8'h37;
	localparam logic [7:0] ADDR_BUF_CTL = 8'h38;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_ACT_THR = 8'h00;
	localparam logic [7:0] RST_INACT_THR = 8'h00;
	localparam logic [7:0] RST_INACT_DUR = 8'h00;
	localparam logic [7:0] RST_ENABLE = 8'h00;
	localparam logic [7:0] RST_ROUTE = 8'h00;
	localparam logic [7:0] RST_FORMAT = 8'h00;
	localparam logic [7:0] RST_BUF_CTL = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned BIT_DRDY = 7;
	localparam int unsigned BIT_ACT = 4;
	localparam int unsigned BIT_INACT = 3;
	localparam int unsigned BIT_WMARK = 1;
	localparam int unsigned BIT_OVR = 0;
	localparam logic [7:0] EVENT_MASK = 8'h9b;
	localparam int unsigned FMT_INVERT = 5;
	localparam int unsigned BUF_MODE_LSB = 6;
	localparam int unsigned BUF_TRIG_PIN = 5;
	localparam int unsigned BUF_SAMPLES_LSB = 0;

	// ----------------------------------------------------------------
	// Sizes and timing
	// ----------------------------------------------------------------
	localparam int unsigned FIFO_DEPTH = 32;
	localparam int unsigned PTR_W = 5;
	localparam int unsigned CNT_W = 6;
	localparam int unsigned AXIS_W = 16;
	localparam int unsigned ACT_SHIFT = 4;
	localparam int unsigned SEC_W = 28;
	localparam int unsigned INACT_UNIT_S = 1;
	localparam int unsigned CLK_HZ = 200000000;
	localparam int unsigned INACT_UNIT_CYCLES = INACT_UNIT_S * CLK_HZ;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {MODE_BYPASS = 2'h0, MODE_FIFO = 2'h1, MODE_STREAM = 2'h2, MODE_TRIGGER = 2'h3} aie_mode_t;
	typedef enum logic [1:0] {TRG_IDLE = 2'h0, TRG_ARMED = 2'h1, TRG_HELD = 2'h3} aie_trig_t;

	typedef struct packed {
		logic [AXIS_W-1:0] z;
		logic [AXIS_W-1:0] y;
		logic [AXIS_W-1:0] x;
	} aie_sample_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} aie_reg_req_t;

	typedef struct packed {
		logic [7:0] act_thr;
		logic [7:0] inact_thr;
		logic [7:0] inact_dur;
		logic [7:0] enable;
		logic [7:0] route;
		logic [7:0] fmt;
		logic [7:0] buf_ctl;
		logic [7:0] flags;
		logic [7:0] rdata;
		logic rvalid;
		logic pin1;
		logic pin2;
		logic [1:0] prev_level;
		aie_sample_t bypass_data;
		logic unread;
		logic quiet;
		logic [7:0] quiet_secs;
		logic [SEC_W-1:0] sec_cnt;
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W-1:0] rd_ptr;
		logic [CNT_W-1:0] count;
		aie_trig_t trig;
		aie_sample_t [FIFO_DEPTH-1:0] mem;
	} aie_state_t;

endpackage

//--- hdl/aie_event_logic.sv
// Purpose: Latched event flags, sample buffer and two interrupt pins of an accelerometer.
// Assumes: Register port and sample inputs are synchronous to sys_clk.
// Notes:   A read of the last data byte consumes one sample.

// What this block does
// - Two push-pull interrupt pins; each enabled source drives exactly one pin.
// - Pins are active high after reset; the format invert bit makes them active low.
// - All events work at once; a shared pin shows any routed source.
// - A source reaches a pin only when enabled; its routing bit picks the pin.
// - Flags are latched; data flags clear when data reads or a buffer control write remove their cause.
// - Non-data flags clear when the host reads the source register.
// - Data ready is set while an unread sample exists, clear otherwise.
// - Activity sets when a measured axis exceeds the activity threshold.
// - Inactivity sets when all axes stay below threshold longer than the duration.
// - The inactivity duration counts whole seconds, up to 255.
// - Watermark sets when the buffer count equals the samples field.
// - Watermark clears once reads bring the count below the samples field.
// - In bypass, overrun sets when a new sample replaces an unread one.
// - In other modes, overrun sets when the buffer becomes full.
// - Overrun clears when the host reads the buffer contents.
// - Buffer holds 32 samples; modes bypass, fifo, stream, trigger chosen by mode field.
// - In bypass the buffer stores nothing and stays empty.
module aie_event_logic
	import aie_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = INACT_UNIT_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire aie_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic sample_valid,
	input wire aie_sample_t sample,
	output logic first_irq_pin,
	output logic second_irq_pin
);

	// ----------------------------------------------------------------
	// Axis magnitudes
	// ----------------------------------------------------------------
	function automatic logic [7:0] aie_mag(input logic [AXIS_W-1:0] v);
		logic [AXIS_W-1:0] a;
		logic [AXIS_W-1:0] q;
		a = v[AXIS_W-1] ? AXIS_W'(~v + 16'h0001) : v;
		q = a >> ACT_SHIFT;
		aie_mag = (q > 16'h00ff) ? 8'hff : q[7:0];
	endfunction

	aie_state_t s;
	aie_state_t next_s;
	logic [2:0][AXIS_W-1:0] axis;
	logic [2:0] axis_over;
	logic [2:0] axis_under;
	logic [1:0] level;
	logic act_set;
	logic ovr_set;
	logic pop;
	logic tick;
	aie_mode_t mode;
	logic [PTR_W-1:0] samples;

	assign axis = {sample.z, sample.y, sample.x};

	for (genvar i = 0; i < 3; i++) begin : g_axis
		assign axis_over[i] = aie_mag(axis[i]) > s.act_thr;
		assign axis_under[i] = aie_mag(axis[i]) < s.inact_thr;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [CNT_W-1:0] cnt;
		logic push;
		logic data_rd;
		aie_sample_t head;
		cnt = s.count;
		push = 1'b0;
		data_rd = 1'b0;
		head = s.bypass_data;
		next_s = s;
		next_s.rvalid = 1'b0;
		act_set = 1'b0;
		ovr_set = 1'b0;
		tick = 1'b0;
		data_rd = reg_req.rd && (reg_req.addr == ADDR_DATA_LAST);

		// Pin levels from the latched, enabled flags.
		level[0] = |(s.flags & s.enable & ~s.route & EVENT_MASK);
		level[1] = |(s.flags & s.enable & s.route & EVENT_MASK);
		next_s.prev_level = level;
		next_s.pin1 = level[0] ^ s.fmt[FMT_INVERT];
		next_s.pin2 = level[1] ^ s.fmt[FMT_INVERT];

		// Register reads.
		head = (aie_mode_t'(s.buf_ctl[BUF_MODE_LSB +: 2]) == MODE_BYPASS) ? s.bypass_data : s.mem[s.rd_ptr];
		if (reg_req.rd) begin
			next_s.rvalid = 1'b1;
			unique case (reg_req.addr)
				ADDR_ACT_THR: next_s.rdata = s.act_thr;
				ADDR_INACT_THR: next_s.rdata = s.inact_thr;
				ADDR_INACT_DUR: next_s.rdata = s.inact_dur;
				ADDR_ENABLE: next_s.rdata = s.enable;
				ADDR_ROUTE: next_s.rdata = s.route;
				ADDR_SOURCE: next_s.rdata = s.flags;
				ADDR_FORMAT: next_s.rdata = s.fmt;
				ADDR_BUF_CTL: next_s.rdata = s.buf_ctl;
				8'h32: next_s.rdata = head.x[7:0];
				8'h33: next_s.rdata = head.x[15:8];
				8'h34: next_s.rdata = head.y[7:0];
				8'h35: next_s.rdata = head.y[15:8];
				8'h36: next_s.rdata = head.z[7:0];
				ADDR_DATA_LAST: next_s.rdata = head.z[15:8];
				default: next_s.rdata = 8'h00;
			endcase
		end

		// Register writes.
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				ADDR_ACT_THR: next_s.act_thr = reg_req.wdata;
				ADDR_INACT_THR: next_s.inact_thr = reg_req.wdata;
				ADDR_INACT_DUR: next_s.inact_dur = reg_req.wdata;
				ADDR_ENABLE: next_s.enable = reg_req.wdata & EVENT_MASK;
				ADDR_ROUTE: next_s.route = reg_req.wdata & EVENT_MASK;
				ADDR_FORMAT: next_s.fmt = reg_req.wdata;
				ADDR_BUF_CTL: next_s.buf_ctl = reg_req.wdata;
				default: next_s.fmt = next_s.fmt;
			endcase
		end
		mode = aie_mode_t'(next_s.buf_ctl[BUF_MODE_LSB +: 2]);
		samples = next_s.buf_ctl[BUF_SAMPLES_LSB +: PTR_W];

		// Non-data flags clear on a source read; a new event wins.
		if (reg_req.rd && (reg_req.addr == ADDR_SOURCE)) begin
			next_s.flags[BIT_ACT] = 1'b0;
			next_s.flags[BIT_INACT] = 1'b0;
		end

		// Activity.
		if (sample_valid && (|axis_over)) begin
			act_set = 1'b1;
			next_s.flags[BIT_ACT] = 1'b1;
		end

		// Inactivity timing in whole seconds.
		if (sample_valid) begin
			next_s.quiet = &axis_under;
		end
		if (!s.quiet) begin
			next_s.sec_cnt = '0;
			next_s.quiet_secs = 8'h00;
		end else if (s.sec_cnt == SEC_W'(SEC_CYCLES - 1)) begin
			tick = 1'b1;
			next_s.sec_cnt = '0;
			if (s.quiet_secs == s.inact_dur) begin
				next_s.flags[BIT_INACT] = 1'b1;
			end else begin
				next_s.quiet_secs = s.quiet_secs + 8'h01;
			end
		end else begin
			next_s.sec_cnt = s.sec_cnt + SEC_W'(1);
		end
		if (sample_valid && !(&axis_under)) begin
			next_s.sec_cnt = '0;
			next_s.quiet_secs = 8'h00;
		end

		// Sample buffer.
		cnt = s.count;
		pop = data_rd && (s.count != '0) && (mode != MODE_BYPASS);
		push = sample_valid && (mode != MODE_BYPASS);
		if (pop) begin
			next_s.rd_ptr = s.rd_ptr + PTR_W'(1);
			cnt = cnt - CNT_W'(1);
			next_s.flags[BIT_OVR] = 1'b0;
		end
		if (push) begin
			if (cnt == CNT_W'(FIFO_DEPTH)) begin
				if (mode == MODE_STREAM || (mode == MODE_TRIGGER && s.trig != TRG_HELD)) begin
					next_s.mem[s.wr_ptr] = sample;
					next_s.wr_ptr = s.wr_ptr + PTR_W'(1);
					next_s.rd_ptr = next_s.rd_ptr + PTR_W'(1);
				end
			end else begin
				next_s.mem[s.wr_ptr] = sample;
				next_s.wr_ptr = s.wr_ptr + PTR_W'(1);
				cnt = cnt + CNT_W'(1);
				if (cnt == CNT_W'(FIFO_DEPTH)) begin
					ovr_set = 1'b1;
				end
			end
		end

		// Trigger mode keeps the newest samples after the selected pin fires.
		unique case (s.trig)
			TRG_IDLE: begin
				if (mode == MODE_TRIGGER) begin
					next_s.trig = TRG_ARMED;
				end
			end
			TRG_ARMED: begin
				if (mode == MODE_TRIGGER && level[s.buf_ctl[BUF_TRIG_PIN]] &&
					!s.prev_level[s.buf_ctl[BUF_TRIG_PIN]]) begin
					next_s.trig = TRG_HELD;
					if (cnt > {1'b0, samples}) begin
						next_s.rd_ptr = next_s.wr_ptr - samples;
						cnt = {1'b0, samples};
					end
				end
			end
			TRG_HELD: begin
				next_s.trig = TRG_HELD;
			end
			default: next_s.trig = TRG_IDLE;
		endcase

		// Bypass holds only the newest sample and empties the buffer.
		if (mode == MODE_BYPASS) begin
			cnt = '0;
			next_s.wr_ptr = '0;
			next_s.rd_ptr = '0;
			next_s.trig = TRG_IDLE;
			if (data_rd) begin
				next_s.unread = 1'b0;
				next_s.flags[BIT_OVR] = 1'b0;
			end
			if (sample_valid) begin
				next_s.bypass_data = sample;
				next_s.unread = 1'b1;
				if (s.unread && !data_rd) begin
					ovr_set = 1'b1;
				end
			end
		end else begin
			next_s.unread = 1'b0;
		end
		next_s.count = cnt;
		if (ovr_set) begin
			next_s.flags[BIT_OVR] = 1'b1;
		end

		// Data-related flags follow their condition.
		next_s.flags[BIT_DRDY] = (mode == MODE_BYPASS) ? next_s.unread : (cnt != '0);
		if (mode != MODE_BYPASS && samples != '0 && cnt == {1'b0, samples}) begin
			next_s.flags[BIT_WMARK] = 1'b1;
		end else if (cnt < {1'b0, samples} || samples == '0) begin
			next_s.flags[BIT_WMARK] = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			s <= '0;
			s.act_thr <= RST_ACT_THR;
			s.inact_thr <= RST_INACT_THR;
			s.inact_dur <= RST_INACT_DUR;
			s.enable <= RST_ENABLE;
			s.route <= RST_ROUTE;
			s.fmt <= RST_FORMAT;
			s.buf_ctl <= RST_BUF_CTL;
			s.trig <= TRG_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata = s.rdata;
	assign reg_rvalid = s.rvalid;
	assign first_irq_pin = s.pin1;
	assign second_irq_pin = s.pin2;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_DISABLED_PINS_IDLE: assert property (@(posedge sys_clk) disable iff (!rstn)
		(s.enable == 8'h00) |=> (first_irq_pin == $past(s.fmt[FMT_INVERT])) && (second_irq_pin == $past(s.fmt[FMT_INVERT])))
		else $error("Disabled sources reached a pin.");
	AST_PIN_FOLLOWS_FLAGS: assert property (@(posedge sys_clk) disable iff (!rstn)
		((s.flags & s.enable & ~s.route & EVENT_MASK) != 8'h00) && !s.fmt[FMT_INVERT] |=> first_irq_pin)
		else $error("First pin missed a routed flag.");
	AST_SECOND_PIN_INVERTED: assert property (@(posedge sys_clk) disable iff (!rstn)
		((s.flags & s.enable & s.route & EVENT_MASK) != 8'h00) && s.fmt[FMT_INVERT] |=> !second_irq_pin)
		else $error("Second pin ignored inversion.");
	AST_ACT_SETS: assert property (@(posedge sys_clk) disable iff (!rstn)
		act_set |=> s.flags[BIT_ACT])
		else $error("Activity flag not set.");
	AST_SOURCE_READ_CLEARS: assert property (@(posedge sys_clk) disable iff (!rstn)
		reg_req.rd && (reg_req.addr == ADDR_SOURCE) && !act_set |=> !s.flags[BIT_ACT])
		else $error("Source read left activity set.");
	AST_INACT_ON_TICK: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(s.flags[BIT_INACT]) |-> $past(tick))
		else $error("Inactivity set without a second tick.");
	AST_BYPASS_EMPTY: assert property (@(posedge sys_clk) disable iff (!rstn)
		(s.buf_ctl[BUF_MODE_LSB +: 2] == MODE_BYPASS) |-> (s.count == '0))
		else $error("Buffer not empty in bypass.");
	AST_WMARK_EQUAL: assert property (@(posedge sys_clk) disable iff (!rstn)
		(s.buf_ctl[BUF_MODE_LSB +: 2] != MODE_BYPASS) && (s.buf_ctl[4:0] != 5'h00) &&
		(s.count == {1'b0, s.buf_ctl[4:0]}) |-> s.flags[BIT_WMARK])
		else $error("Watermark missing at level.");
	AST_WMARK_BELOW: assert property (@(posedge sys_clk) disable iff (!rstn)
		(s.count < {1'b0, s.buf_ctl[4:0]}) |-> !s.flags[BIT_WMARK])
		else $error("Watermark held below level.");
	AST_FULL_OVERRUN: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(s.count == CNT_W'(FIFO_DEPTH)) |-> s.flags[BIT_OVR])
		else $error("Overrun not set on full.");
	AST_POP_CLEARS_OVR: assert property (@(posedge sys_clk) disable iff (!rstn)
		pop && !ovr_set |=> !s.flags[BIT_OVR])
		else $error("Overrun held after read.");
	AST_BYPASS_OVERRUN: assert property (@(posedge sys_clk) disable iff (!rstn)
		(mode == MODE_BYPASS) && sample_valid && s.unread && !(reg_req.rd && reg_req.addr == ADDR_DATA_LAST)
		|=> s.flags[BIT_OVR] ##1 1'b1)
		else $error("Bypass overrun missed.");
	AST_DRDY_EMPTY: assert property (@(posedge sys_clk) disable iff (!rstn)
		(s.count == '0) && (s.buf_ctl[BUF_MODE_LSB +: 2] != MODE_BYPASS) && !sample_valid && !reg_req.wr
		|=> !s.flags[BIT_DRDY])
		else $error("Data ready set with nothing unread.");
	AST_ONE_PIN_PER_SOURCE: assert property (@(posedge sys_clk) disable iff (!rstn)
		((s.enable & ~s.route & EVENT_MASK) == (s.enable & EVENT_MASK)) && !s.fmt[FMT_INVERT] |=> !second_irq_pin)
		else $error("Source routed to the first pin reached the second.");
	AST_TRIGGER_KEEPS_LAST: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(s.trig == TRG_HELD) |-> (s.count <= {1'b0, s.buf_ctl[4:0]}))
		else $error("Trigger kept more than the samples field.");
	AST_BYPASS_DRDY: assert property (@(posedge sys_clk) disable iff (!rstn)
		(mode == MODE_BYPASS) && sample_valid |=> s.flags[BIT_DRDY])
		else $error("Data ready missed a new sample.");
	AST_BYPASS_READ_CLEARS_OVR: assert property (@(posedge sys_clk) disable iff (!rstn)
		(mode == MODE_BYPASS) && reg_req.rd && (reg_req.addr == ADDR_DATA_LAST) && !sample_valid
		|=> !s.flags[BIT_OVR])
		else $error("Overrun held after a bypass data read.");

	COV_TRIGGER_HELD: cover property (@(posedge sys_clk) disable iff (!rstn) s.trig == TRG_ARMED ##1 s.trig == TRG_HELD);
	COV_WMARK: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(s.flags[BIT_WMARK]));
	COV_INACT: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(s.flags[BIT_INACT]));
	COV_FULL: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(s.flags[BIT_OVR]) && s.count == CNT_W'(FIFO_DEPTH));
	COV_BYPASS_OVERRUN: cover property (@(posedge sys_clk) disable iff (!rstn) (mode == MODE_BYPASS) && ovr_set);

endmodule // aie_event_logic

//--- tb/aie_host_model.sv
// Purpose: Host processor model driving the register port of the event logic.
// Assumes: Requests change 1 ns after a rising edge of sys_clk.
// Notes:   A read strobe lasts one cycle; data is taken with reg_rvalid.
module aie_host_model
	import aie_pkg::*;
(
	input wire logic sys_clk,
	output aie_reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	timeunit 1ns;
	timeprecision 1ps;

	// --------------------------------------------------------------
	// Register port cycles
	// --------------------------------------------------------------
	initial reg_req = '0;

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk) #1;
		reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk) #1;
		reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(posedge sys_clk) #1;
		reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge sys_clk) #1;
		reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
		d = reg_rdata;
		ok = reg_rvalid;
	endtask
endmodule // aie_host_model

//--- tb/tb_top.sv
// Purpose: Self-checking bench of the accelerometer event logic.
// Assumes: One second of inactivity time is shortened to 20 cycles.
// Notes:   Random values come from a fixed seed.
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module tb_top
	import aie_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic sys_clk, rstn, sample_valid, ok, first_irq_pin, second_irq_pin;
	aie_reg_req_t reg_req;
	logic [7:0] reg_rdata, d, thr, r;
	logic reg_rvalid;
	aie_sample_t sample, s;
	int errors, n_checks, seed, cycles;
	logic [7:0] addrs [9] = '{8'h24, 8'h25, 8'h26, 8'h2e, 8'h2f, 8'h30, 8'h31, 8'h38, 8'h10};

	aie_event_logic #(.SEC_CYCLES(20)) i_aie_event_logic (.sys_clk(sys_clk), .rstn(rstn), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sample_valid(sample_valid), .sample(sample),
		.first_irq_pin(first_irq_pin), .second_irq_pin(second_irq_pin));
	aie_host_model i_aie_host_model (.sys_clk(sys_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	function automatic logic exp_pin(logic [7:0] fl, logic [7:0] en, logic [7:0] rt, logic inv, logic sec);
		return (|(fl & en & EVENT_MASK & (sec ? rt : ~rt))) ^ inv;
	endfunction

	task automatic rreg(input logic [7:0] a, output logic [7:0] v);
		i_aie_host_model.rd(a, v, ok);
		`CHK(ok, 1'b1)
	endtask

	task automatic push(input logic [15:0] x, input logic [15:0] y);
		@(posedge sys_clk) #1;
		sample_valid = 1'b1;
		sample = '{z: 16'h0000, y: y, x: x};
		@(posedge sys_clk) #1;
		sample_valid = 1'b0;
		sample = ~sample;
	endtask

	task automatic pop(output aie_sample_t v);
		logic [7:0] b;
		for (int i = 0; i < 6; i++) begin
			rreg(ADDR_DATA_FIRST + 8'(i), b);
			v[i*8 +: 8] = b;
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			finish_test();
		end
	end

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	initial begin
		seed = 74586;
		rstn = 1'b0;
		sample_valid = 1'b0;
		sample = '0;
		repeat (10) @(posedge sys_clk);
		#1 rstn = 1'b1;
		wt(1);
		`CHK({second_irq_pin, first_irq_pin}, 2'b00)
		foreach (addrs[i]) begin
			rreg(addrs[i], d);
			`CHK(d, 8'h00)
		end
		for (int i = 0; i < 12; i++) begin
			r = addrs[i % 9];
			d = 8'($random(seed));
			i_aie_host_model.wr(r, d);
			rreg(r, thr);
			`CHK(thr, (r == 8'h30 || r == 8'h10) ? 8'h00 : (r == 8'h2e || r == 8'h2f) ? d & EVENT_MASK : d)
			i_aie_host_model.wr(r, 8'h00);
		end
		thr = 8'(($random(seed) & 127) + 1);
		i_aie_host_model.wr(ADDR_ACT_THR, thr);
		i_aie_host_model.wr(ADDR_ROUTE, 8'h10);
		i_aie_host_model.wr(ADDR_ENABLE, 8'h90);
		push({4'h0, thr, 4'hf}, 16'h0000);
		rreg(ADDR_SOURCE, d);
		`CHK(d, 8'h80)
		pop(s);
		`CHK(s.x, {4'h0, thr, 4'hf})
		push(16'h0000, -{4'h0, thr + 8'h01, 4'h0});
		wt(3);
		`CHK(first_irq_pin, exp_pin(8'h90, 8'h90, 8'h10, 1'b0, 1'b0))
		`CHK(second_irq_pin, exp_pin(8'h90, 8'h90, 8'h10, 1'b0, 1'b1))
		pop(s);
		wt(3);
		`CHK({second_irq_pin, first_irq_pin}, 2'b10)
		rreg(ADDR_SOURCE, d);
		`CHK(d, 8'h10)
		rreg(ADDR_SOURCE, d);
		`CHK(d, 8'h00)
		wt(3);
		`CHK(second_irq_pin, 1'b0)
		push(16'h0001, 16'h0000);
		push(16'h0002, 16'h0000);
		rreg(ADDR_SOURCE, d);
		`CHK(d, 8'h81)
		pop(s);
		rreg(ADDR_SOURCE, d);
		`CHK(d, 8'h00)
		i_aie_host_model.wr(ADDR_FORMAT, 8'h20);
		wt(3);
		`CHK({second_irq_pin, first_irq_pin}, 2'b11)
		i_aie_host_model.wr(ADDR_ENABLE, 8'h00);
		i_aie_host_model.wr(ADDR_ROUTE, 8'h90);
		i_aie_host_model.wr(ADDR_ENABLE, 8'h10);
		push(-{4'h0, thr + 8'h01, 4'h0}, 16'h0000);
		wt(3);
		`CHK({second_irq_pin, first_irq_pin}, {exp_pin(8'h90, 8'h10, 8'h90, 1'b1, 1'b1), 1'b1})
		i_aie_host_model.wr(ADDR_ENABLE, 8'h00);
		i_aie_host_model.wr(ADDR_FORMAT, 8'h00);
		pop(s);
		i_aie_host_model.wr(ADDR_ACT_THR, 8'hff);
		i_aie_host_model.wr(ADDR_BUF_CTL, 8'h01);
		i_aie_host_model.wr(ADDR_INACT_THR, 8'h08);
		i_aie_host_model.wr(ADDR_INACT_DUR, 8'h01);
		push(16'h0000, 16'h0000);
		rreg(ADDR_SOURCE, d);
		`CHK(d & 8'h02, 8'h00)
		pop(s);
		wt(10);
		rreg(ADDR_SOURCE, d);
		`CHK(d & 8'h08, 8'h00)
		wt(50);
		rreg(ADDR_SOURCE, d);
		`CHK(d & 8'h08, 8'h08)
		i_aie_host_model.wr(ADDR_INACT_THR, 8'h00);
		rreg(ADDR_SOURCE, d);
		for (int m = 1; m < 4; m++) begin
			i_aie_host_model.wr(ADDR_BUF_CTL, {2'(m), 6'h04});
			for (int k = 0; k < 33; k++) begin
				push(16'(k), 16'h0000);
				if (k == 2 || k == 3) begin
					rreg(ADDR_SOURCE, d);
					`CHK(d & 8'h02, (k == 3) ? 8'h02 : 8'h00)
				end
			end
			rreg(ADDR_SOURCE, d);
			`CHK(d & 8'h83, 8'h83)
			for (int k = 0; k < 32; k++) begin
				pop(s);
				`CHK(s.x, 16'(k + (m != 1)))
				if (k == 0 || k == 27 || k == 28)
					rreg(ADDR_SOURCE, d);
				if (k == 0)
					`CHK(d & 8'h01, 8'h00)
				if (k == 27 || k == 28)
					`CHK(d & 8'h02, (k == 27) ? 8'h02 : 8'h00)
			end
			rreg(ADDR_SOURCE, d);
			`CHK(d & 8'h80, 8'h00)
			i_aie_host_model.wr(ADDR_BUF_CTL, 8'h00);
		end
		i_aie_host_model.wr(ADDR_ACT_THR, thr);
		i_aie_host_model.wr(ADDR_ROUTE, 8'h00);
		i_aie_host_model.wr(ADDR_BUF_CTL, 8'hc4);
		rreg(ADDR_SOURCE, d);
		i_aie_host_model.wr(ADDR_ENABLE, 8'h10);
		for (int k = 0; k < 10; k++) begin
			push(16'(k), 16'h0000);
		end
		push({4'h0, thr + 8'h01, 4'h0}, 16'h0000);
		wt(2);
		`CHK({second_irq_pin, first_irq_pin}, 2'b01)
		for (int k = 0; k < 4; k++) begin
			pop(s);
			`CHK(s.x, (k < 3) ? 16'(k + 7) : {4'h0, thr + 8'h01, 4'h0})
		end
		rreg(ADDR_SOURCE, d);
		`CHK(d & 8'h80, 8'h00)
		finish_test();
	end
endmodule // tb_top
